/* dv/core_model.sv */
`timescale 1ns/1ns
// Core side that presents interrupts to the block
module core_model (
    input  wire logic clk,          // Device clock
    output logic      present,      // Presentation pulse
    output logic [2:0] present_prio, // Priority with pulse
    output logic [5:0] present_vec   // Vector with pulse
);
    initial {present, present_prio, present_vec} = 10'h000;
    // Noise between pulses, so a stale value never looks valid
    always @(negedge clk)
        if (!present)
        begin
            present_prio <= present_prio + 3'h3;
            present_vec  <= present_vec ^ 6'h2d;
        end
    // One-cycle presentation
    task automatic offer(input logic [2:0] p, input logic [5:0] v);
        present      <= 1'b1;
        present_prio <= p;
        present_vec  <= v;
        @(posedge clk);
        present <= 1'b0;
        @(posedge clk);
    endtask
endmodule

/* dv/interrupt_status_proximity_timer_tb.sv */
`timescale 1ns/1ns
module interrupt_status_proximity_timer_tb;
    localparam logic [7:0] ST = ipt_pkg::ADDR_STATUS;
    localparam logic [7:0] RL = ipt_pkg::ADDR_RELOAD;
    localparam logic [7:0] CT = ipt_pkg::ADDR_CTRL;
    localparam logic [7:0] IS = ipt_pkg::ADDR_IRQ_ST;
    logic        clk = 1'b0, reset_n = 1'b0, wr = 1'b0, rd = 1'b0;
    logic        tmr_trigger = 1'b0, rd_q = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, st, seed = 32'h0303;
    logic        present, tmr_expired, irq;
    logic [2:0]  present_prio;
    logic [5:0]  present_vec;
    logic [31:0] exp_q[$];
    int          n_mismatch = 0, n_compared = 0, n3, n7;

    always #5 clk = ~clk;
    core_model core (.clk(clk), .present(present),
        .present_prio(present_prio), .present_vec(present_vec));
    interrupt_status_proximity_timer uut (.clk(clk), .reset_n(reset_n),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .present(present), .present_prio(present_prio),
        .present_vec(present_vec), .tmr_trigger(tmr_trigger),
        .tmr_expired(tmr_expired), .irq(irq));

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, g);
        n_compared++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // A read leaves its expectation for the monitor; gap avoids re-drive
    task automatic bus(input logic w, input logic [7:0] a, logic [31:0] d);
        if (!w) exp_q.push_back(d);
        wr <= w;
        rd <= !w;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
        @(posedge clk);
    endtask
    // Cycles from trigger to expiry, capped so a dead timer cannot hang
    task automatic meas(input logic [31:0] r, output int n);
        bus(1'b1, RL, r);
        tmr_trigger <= 1'b1;
        @(posedge clk);
        tmr_trigger <= 1'b0;
        n = 0;
        do
        begin
            @(negedge clk);
            n++;
        end
        while (tmr_expired !== 1'b1 && n < 100);
        @(posedge clk);
    endtask
    task automatic close_out();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Read data stand only in the cycle after the strobe
    always @(posedge clk) rd_q <= rd;
    always @(negedge clk)
        if (rd_q) chk("rdata", exp_q.pop_front(), rdata);
    initial
    begin
        #100000;
        n_mismatch++;
        close_out();
    end
    initial
    begin
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        bus(1'b0, ST, 32'h0);
        bus(1'b0, RL, ipt_pkg::RELOAD_RST);
        bus(1'b0, CT, {30'h0, ipt_pkg::CTRL_RST});
        bus(1'b0, 8'h20, ipt_pkg::UNMAPPED);
        bus(1'b1, ST, 32'hffff_ffff);
        bus(1'b0, ST, 32'h0);
        seed = xs(seed);
        bus(1'b1, RL, seed);
        bus(1'b0, RL, seed);
        // Write then read with no gap, as the master may
        seed = xs(seed);
        exp_q.push_back(seed);
        wr <= 1'b1;
        addr <= RL;
        wdata <= seed;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        $display("test registers done");
        bus(1'b1, ipt_pkg::ADDR_IRQ_MSK, 32'h2);
        bus(1'b0, ipt_pkg::ADDR_IRQ_MSK, 32'h2);
        for (int i = 0; i < 4; i++)
        begin
            seed = xs(seed);
            core.offer(seed[10:8], seed[5:0]);
            st = seed & 32'h0000_073f;
            bus(1'b0, ST, st);
        end
        bus(1'b0, ST, st);
        core.offer(3'h7, 6'h3f);
        bus(1'b0, ST, 32'h73f);
        chk("irq", 32'h0, {31'h0, irq});
        $display("test status done");
        bus(1'b1, CT, 32'h2);
        meas(32'h0, n3);
        chk("idle", 32'd100, 32'(n3));
        bus(1'b1, CT, 32'h3);
        meas(32'h3, n3);
        meas(32'h7, n7);
        chk("span", 32'h4, 32'(n7 - n3));
        chk("delay", 32'd9, 32'(n7));
        // Counter rests at zero once it has expired
        bus(1'b0, ipt_pkg::ADDR_TIMER, 32'h0);
        repeat (2) @(negedge clk);
        chk("irq", 32'h1, {31'h0, irq});
        @(posedge clk);
        bus(1'b0, IS, 32'h3);
        bus(1'b1, IS, 32'h3);
        bus(1'b0, IS, 32'h0);
        chk("irq", 32'h0, {31'h0, irq});
        $display("test timer done");
        close_out();
    end
endmodule

/* rtl/interrupt_presented_status_pkg.sv */
package ipt_pkg;
    // ------------------------------------------------------------
    // Register map (word offsets are byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_STATUS  = 8'h00;
    localparam logic [7:0] ADDR_RELOAD  = 8'h04;
    localparam logic [7:0] ADDR_TIMER   = 8'h08;
    localparam logic [7:0] ADDR_CTRL    = 8'h0c;
    localparam logic [7:0] ADDR_IRQ_ST  = 8'h10;
    localparam logic [7:0] ADDR_IRQ_MSK = 8'h14;

    // ------------------------------------------------------------
    // Field layout
    // ------------------------------------------------------------
    localparam int PRIO_LSB = 8;
    localparam int PRIO_W   = 3;
    localparam int VEC_LSB  = 0;
    localparam int VEC_W    = 6;

    // Control register bits
    localparam int CTRL_TMR_EN = 0;
    localparam int CTRL_SINGLE = 1;

    // Interrupt event bits
    localparam int EV_PRESENT = 0;
    localparam int EV_EXPIRE  = 1;
    localparam int EV_W       = 2;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [31:0] RELOAD_RST = 32'h0000_0000;
    localparam logic [1:0]  CTRL_RST   = 2'h2;
    localparam logic [31:0] UNMAPPED   = 32'h0000_0000;
endpackage

/* rtl/interrupt_status_proximity_timer.sv */
// Strobed register access and the address map were decided locally.
`timescale 1ns/1ns
// How it works
// - Priority of latest presented interrupt in bits 10:8
// - Vector of latest presented interrupt in bits 5:0
// - Unimplemented status bits always read zero
// - 32-bit reload register, read/write, resets zero
// - Trigger event loads timer from reload register
module interrupt_status_proximity_timer (
    input  wire logic        clk,          // 100 MHz clock
    input  wire logic        reset_n,      // Async reset, active low
    input  wire logic [7:0]  addr,         // Register byte address
    input  wire logic [31:0] wdata,        // Write data
    input  wire logic        wr,           // Write strobe
    input  wire logic        rd,           // Read strobe
    output logic      [31:0] rdata,        // Read data, cycle after rd
    input  wire logic        present,      // Core presented an interrupt
    input  wire logic [2:0]  present_prio, // Priority of presentation
    input  wire logic [5:0]  present_vec,  // Vector of presentation
    input  wire logic        tmr_trigger,  // Event triggering timer
    output logic             tmr_expired,  // One-cycle expiry pulse
    output logic             irq           // Level interrupt output
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [2:0]  prio;
        logic [5:0]  vec;
        logic [31:0] reload;
        logic [31:0] timer;
        logic        running;
        logic [1:0]  ctrl;
        logic [1:0]  irq_st;
        logic [1:0]  irq_msk;
        logic [31:0] rdata;
        logic        expired;
        logic        irq;
    } state_t;

    state_t s_q;
    state_t s_d;

    // Status word with reserved bits forced to zero
    function automatic logic [31:0] status_word(input logic [2:0] p,
                                                input logic [5:0] v);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[ipt_pkg::PRIO_LSB +: ipt_pkg::PRIO_W] = p;
        w[ipt_pkg::VEC_LSB +: ipt_pkg::VEC_W]   = v;
        return w;
    endfunction

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    // Trigger outranks the countdown so a fresh event restarts it whenever CTRL_TMR_EN is set
    always_comb
    begin
        logic [1:0] ev;
        ev = 2'h0;
        s_d = s_q;
        s_d.expired = 1'b0;
        // Capture only on a presentation, hold otherwise
        if (present)
        begin
            s_d.prio = present_prio;
            s_d.vec  = present_vec;
            ev[ipt_pkg::EV_PRESENT] = 1'b1;
        end
        // Proximity countdown
        if (tmr_trigger && s_q.ctrl[ipt_pkg::CTRL_TMR_EN])
        begin
            s_d.timer   = s_q.reload;
            s_d.running = 1'b1;
        end
        else if (s_q.running)
        begin
            if (s_q.timer == 32'h0000_0000)
            begin
                s_d.running = 1'b0;
                s_d.expired = 1'b1;
                ev[ipt_pkg::EV_EXPIRE] = 1'b1;
            end
            else
            begin
                s_d.timer = s_q.timer - 32'h0000_0001;
            end
        end
        // Register writes
        if (wr)
        begin
            unique case (addr)
                ipt_pkg::ADDR_RELOAD:  s_d.reload = wdata;
                ipt_pkg::ADDR_CTRL:    s_d.ctrl = wdata[1:0];
                ipt_pkg::ADDR_IRQ_MSK: s_d.irq_msk = wdata[1:0];
                ipt_pkg::ADDR_IRQ_ST:  s_d.irq_st = s_q.irq_st & ~wdata[1:0];
                default: ;
            endcase
        end
        // Set wins over a same-cycle clear
        s_d.irq_st = s_d.irq_st | ev;
        s_d.irq = |(s_d.irq_st & s_d.irq_msk);
        // Read data, valid only the cycle after rd
        s_d.rdata = 32'h0000_0000;
        if (rd)
        begin
            unique case (addr)
                ipt_pkg::ADDR_STATUS:  s_d.rdata = status_word(s_q.prio, s_q.vec);
                ipt_pkg::ADDR_RELOAD:  s_d.rdata = s_q.reload;
                ipt_pkg::ADDR_TIMER:   s_d.rdata = s_q.timer;
                ipt_pkg::ADDR_CTRL:    s_d.rdata = {30'h0, s_q.ctrl};
                ipt_pkg::ADDR_IRQ_ST:  s_d.rdata = {30'h0, s_q.irq_st};
                ipt_pkg::ADDR_IRQ_MSK: s_d.rdata = {30'h0, s_q.irq_msk};
                default: s_d.rdata = ipt_pkg::UNMAPPED;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            s_q <= '0;
            s_q.reload <= ipt_pkg::RELOAD_RST;
            s_q.ctrl <= ipt_pkg::CTRL_RST;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign rdata       = s_q.rdata;
    assign tmr_expired = s_q.expired;
    assign irq         = s_q.irq;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    prio_capture_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        present |=> s_q.prio == $past(present_prio))
        else $error("priority not captured");

    vec_capture_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        present |=> s_q.vec == $past(present_vec))
        else $error("vector not captured");

    status_zero_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        rd && addr == ipt_pkg::ADDR_STATUS
        |=> rdata[31:11] == 21'h0 && rdata[7:6] == 2'h0)
        else $error("reserved status bits not zero");

    reload_rw_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        wr && addr == ipt_pkg::ADDR_RELOAD ##1
        rd && addr == ipt_pkg::ADDR_RELOAD
        |=> rdata == $past(wdata, 2))
        else $error("reload readback wrong");

    timer_load_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        tmr_trigger && s_q.ctrl[ipt_pkg::CTRL_TMR_EN]
        |=> s_q.timer == $past(s_q.reload) && s_q.running)
        else $error("timer not loaded");

    field_hold_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        !present |=> $stable(s_q.prio) && $stable(s_q.vec))
        else $error("status changed without presentation");

    irq_level_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        irq == |(s_q.irq_st & s_q.irq_msk))
        else $error("irq disagrees with status");

    expire_pulse_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        tmr_expired |=> !tmr_expired)
        else $error("expiry longer than a cycle");
endmodule
